// file: hdl/drp_profile_regs.sv
// Reference profile register bank of the first digital loop, on APB.
//
// Behaviour
// - Reference A priority in bits [2:1], 0 highest, resets to 0.
// - Bit 0 enables locking to reference A; resets to 1.
// - Reference B priority register mirrors A: priority [2:1], enable bit 0.
// - Reference A bandwidth is 16 bits over two bytes, 0.1 Hz per count.
// - Bandwidth scaling factor resets to 500, a 50 Hz loop.
// - Filter bit 1 picks normal or high phase margin; resets to normal.
// - Integer divider minus one is 17 bits over three bytes.
// - Integer divider field resets to 0x007CB, dividing by 1996.
// - Fractional numerator is 23 bits over three bytes, resets to 4.
// - Fractional modulus is 23 bits like the numerator, resets to 5.
`timescale 1ns/100ps
`default_nettype none

module drp_profile_regs #(
    parameter int ADDR_W = 16
) (
    // Clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reference currently selected by the loop
    input wire drp_pkg::drp_ref_sel_t ref_sel,
    // Profile of reference B, held by the neighbouring bank
    input wire logic [15:0] ref_b_bw_scale,
    input wire logic ref_b_filter_high_pm,
    input wire logic [16:0] ref_b_fb_integer_part,
    input wire logic [22:0] ref_b_fb_frac_numerator,
    input wire logic [22:0] ref_b_fb_frac_modulus,
    // Switchover settings of both references
    output logic [1:0] ref_input_a_priority,
    output logic ref_input_a_enable,
    output logic [1:0] ref_input_b_priority,
    output logic ref_input_b_enable,
    // Profile of the selected reference, to the first digital loop
    output logic [15:0] sel_bw_scale,
    output logic sel_filter_high_pm,
    output logic [16:0] sel_fb_integer_part,
    output logic [17:0] sel_effective_integer_divide,
    output logic [22:0] sel_fb_frac_numerator,
    output logic [22:0] sel_fb_frac_modulus
);
    import drp_pkg::*;

    // ********************************************************************
    // Address decode
    // ********************************************************************
    logic [7:0] regs_q [DRP_NUM_REGS];
    logic [ADDR_W-3:0] word_idx;
    logic [ADDR_W-3:0] slot_wide;
    logic [3:0] slot;
    logic hit;
    logic setup;
    logic wr_take;

    assign word_idx = paddr[ADDR_W-1:2];
    assign slot_wide = word_idx - (ADDR_W-2)'(DRP_IDX_BASE);
    assign slot = slot_wide[3:0];
    // Unaligned addresses are treated as unmapped rather than aliased.
    assign hit = (paddr[1:0] == 2'b00)
        && (word_idx >= (ADDR_W-2)'(DRP_IDX_BASE))
        && (word_idx <= (ADDR_W-2)'(DRP_IDX_REF_B_PRIORITY_ENABLE));
    assign setup = psel && !penable;
    assign wr_take = pce && psel && penable && pready && pwrite && hit
        && pstrb[0];

    // ********************************************************************
    // Bus answer
    // ********************************************************************
    // The answer is prepared in the setup cycle, so an access phase takes exactly
    // one cycle when pce is high in the setup cycle, and prdata comes straight from a register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (pce) begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (pce) begin
            pslverr <= setup && !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (pce) begin
            if (setup && !pwrite && hit) begin
                prdata <= {24'h00_0000, regs_q[slot]};
            end else if (setup) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ********************************************************************
    // Register storage
    // ********************************************************************
    // Only the low byte lane carries data; reserved bits are masked at
    // write time so that they can never hold a one.
    for (genvar i = 0; i < DRP_NUM_REGS; i++) begin : g_reg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                regs_q[i] <= DRP_RESET[i];
            end else if (wr_take && (slot == 4'(i))) begin
                regs_q[i] <= pwdata[7:0] & DRP_WMASK[i];
            end
        end
    end

    // ********************************************************************
    // Field assembly
    // ********************************************************************
    logic [15:0] a_bw_scale;
    logic a_filter_high_pm;
    logic [16:0] a_int_part;
    logic [22:0] a_frac_num;
    logic [22:0] a_frac_mod;

    assign a_bw_scale = {regs_q[DRP_S_BW_HI], regs_q[DRP_S_BW_LO]};
    assign a_filter_high_pm = regs_q[DRP_S_FILT][DRP_FILTER_BIT];
    assign a_int_part = {regs_q[DRP_S_INT_TOP][0],
        regs_q[DRP_S_INT_MID], regs_q[DRP_S_INT_LO]};
    assign a_frac_num = {regs_q[DRP_S_NUM_TOP][6:0],
        regs_q[DRP_S_NUM_MID], regs_q[DRP_S_NUM_LO]};
    assign a_frac_mod = {regs_q[DRP_S_MOD_TOP][6:0],
        regs_q[DRP_S_MOD_MID], regs_q[DRP_S_MOD_LO]};

    // ********************************************************************
    // Switchover settings
    // ********************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_input_a_priority <= 2'h0;
            ref_input_a_enable <= 1'b1;
            ref_input_b_priority <= 2'h0;
            ref_input_b_enable <= 1'b1;
        end else if (pce) begin
            ref_input_a_priority <=
                regs_q[DRP_S_A_PRIO][DRP_PRIO_MSB:DRP_PRIO_LSB];
            ref_input_a_enable <= regs_q[DRP_S_A_PRIO][DRP_ENABLE_BIT];
            ref_input_b_priority <=
                regs_q[DRP_S_B_PRIO][DRP_PRIO_MSB:DRP_PRIO_LSB];
            ref_input_b_enable <= regs_q[DRP_S_B_PRIO][DRP_ENABLE_BIT];
        end
    end

    // ********************************************************************
    // Profile of the selected reference
    // ********************************************************************
    // The stored field is the divider minus one, so the loop is handed the
    // true integer part; this costs one adder but saves it in the loop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_bw_scale <= DRP_BW_SCALE_RESET;
            sel_filter_high_pm <= 1'b0;
            sel_fb_integer_part <= DRP_INT_DIV_RESET;
            sel_effective_integer_divide <= {1'b0, DRP_INT_DIV_RESET}
                + 18'h0_0001;
            sel_fb_frac_numerator <= DRP_FRAC_NUM_RESET;
            sel_fb_frac_modulus <= DRP_FRAC_MOD_RESET;
        end else if (pce) begin
            unique case (ref_sel)
                DRP_SEL_REF_A: begin
                    sel_bw_scale <= a_bw_scale;
                    sel_filter_high_pm <= a_filter_high_pm;
                    sel_fb_integer_part <= a_int_part;
                    sel_effective_integer_divide <=
                        {1'b0, a_int_part} + 18'h0_0001;
                    sel_fb_frac_numerator <= a_frac_num;
                    sel_fb_frac_modulus <= a_frac_mod;
                end
                DRP_SEL_REF_B: begin
                    sel_bw_scale <= ref_b_bw_scale;
                    sel_filter_high_pm <= ref_b_filter_high_pm;
                    sel_fb_integer_part <= ref_b_fb_integer_part;
                    sel_effective_integer_divide <=
                        {1'b0, ref_b_fb_integer_part} + 18'h0_0001;
                    sel_fb_frac_numerator <= ref_b_fb_frac_numerator;
                    sel_fb_frac_modulus <= ref_b_fb_frac_modulus;
                end
            endcase
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    // Flags that remember whether a field was written since reset, so the
    // reset values can be checked for as long as they should stand.
    logic bw_touched_q;
    logic int_touched_q;
    logic mod_touched_q;
    logic wr_bw;
    logic wr_int;
    logic wr_mod;

    assign wr_bw = wr_take && ((slot == 4'(DRP_S_BW_LO))
        || (slot == 4'(DRP_S_BW_HI)));
    assign wr_int = wr_take && (slot >= 4'(DRP_S_INT_LO))
        && (slot <= 4'(DRP_S_INT_TOP));
    assign wr_mod = wr_take && (slot >= 4'(DRP_S_MOD_LO))
        && (slot <= 4'(DRP_S_MOD_TOP));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_touched_q <= 1'b0;
            int_touched_q <= 1'b0;
            mod_touched_q <= 1'b0;
        end else if (pce) begin
            bw_touched_q <= bw_touched_q || wr_bw;
            int_touched_q <= int_touched_q || wr_int;
            mod_touched_q <= mod_touched_q || wr_mod;
        end
    end

    sequence write_to_s(int s);
        wr_take && (slot == 4'(s));
    endsequence

    sequence sel_a_held_s;
        pce && (ref_sel == DRP_SEL_REF_A) ##1
            pce && (ref_sel == DRP_SEL_REF_A);
    endsequence

    prio_a_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_A_PRIO) ##1 pce |->
            ##1 ref_input_a_priority == $past(pwdata[2:1], 2))
        else $error("Reference A priority does not follow the write.");

    enable_a_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_A_PRIO) ##1 pce |->
            ##1 ref_input_a_enable == $past(pwdata[0], 2))
        else $error("Reference A enable does not follow the write.");

    ref_b_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_B_PRIO) ##1 pce |->
            ##1 {ref_input_b_priority, ref_input_b_enable}
                == $past(pwdata[2:0], 2))
        else $error("Reference B priority or enable is wrong.");

    bw_high_byte_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_BW_HI) |=> a_bw_scale[15:8] == $past(pwdata[7:0]))
        else $error("Bandwidth high byte is not stored in bits 15 to 8.");

    bw_reset_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !bw_touched_q |-> a_bw_scale == 16'h01F4)
        else $error("Bandwidth scaling factor lost its reset value.");

    filter_select_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_a_held_s |->
            sel_filter_high_pm == $past(regs_q[DRP_S_FILT][1]))
        else $error("Loop filter choice does not reach the loop.");

    int_top_bit_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_INT_TOP) |=> a_int_part[16] == $past(pwdata[0]))
        else $error("Integer divider bit 16 is not taken from bit 0.");

    int_reset_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !int_touched_q |-> a_int_part == 17'h0_07CB)
        else $error("Integer divider field lost its reset value.");

    num_top_mask_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_NUM_TOP) |=>
            a_frac_num[22:16] == $past(pwdata[6:0])
            && regs_q[DRP_S_NUM_TOP][7] == 1'b0)
        else $error("Numerator top byte stored wrongly.");

    mod_reset_value_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mod_touched_q |-> a_frac_mod == 23'h00_0005)
        else $error("Fractional modulus lost its reset value.");

    eff_divide_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_a_held_s |->
            sel_effective_integer_divide
                == 18'($past(a_int_part)) + 18'h0_0001)
        else $error("Effective divide is not the stored field plus one.");

    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite |-> prdata[31:8] == 24'h00_0000
            && (regs_q[DRP_S_FILT] & 8'hFD) == 8'h00
            && (regs_q[DRP_S_A_PRIO] & 8'hF8) == 8'h00)
        else $error("A reserved bit reads as one.");

    unmapped_error_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pce && setup && !hit |=> pready && pslverr)
        else $error("Unmapped access was not answered with an error.");

    bw_low_byte_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        write_to_s(DRP_S_BW_LO) |=> a_bw_scale[7:0] == $past(pwdata[7:0]))
        else $error("Bandwidth low byte is not stored in bits 7 to 0.");

    // The access phase is one cycle long when pce is high in the setup cycle, so a master
    // never waits then; a low clock enable in the setup cycle leaves pready low and the access never ends.
    ready_after_setup_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pce && setup |=> pready)
        else $error("Setup cycle was not answered in the next cycle.");

    ready_one_cycle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pce && penable |=> !pready)
        else $error("Ready stood longer than one access cycle.");

    unmapped_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pce && setup && !hit |=> prdata == 32'h0000_0000)
        else $error("Unmapped access returned data.");

    freeze_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !pce |=> $stable(sel_bw_scale) && $stable(sel_fb_integer_part)
            && $stable(ref_input_a_enable) && $stable(pready))
        else $error("State moved while the clock enable was low.");

    ref_b_path_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        pce && (ref_sel == DRP_SEL_REF_B) |=>
            sel_fb_integer_part == $past(ref_b_fb_integer_part)
            && sel_effective_integer_divide
                == 18'($past(ref_b_fb_integer_part)) + 18'h0_0001)
        else $error("Reference B divider does not reach the loop.");

endmodule : drp_profile_regs

`default_nettype wire

// file: common/drp_pkg.sv
// Constants for the reference profile register bank of the first digital loop.
package drp_pkg;

    // ********************************************************************
    // Register indices; the byte address on the bus is four times these.
    // ********************************************************************
    localparam int DRP_NUM_REGS = 14;
    localparam logic [11:0] DRP_IDX_BASE = 12'h0440;
    localparam logic [11:0] DRP_IDX_REF_A_PRIORITY_ENABLE = 12'h0440;
    localparam logic [11:0] DRP_IDX_REF_A_BW_SCALE_LOW = 12'h0441;
    localparam logic [11:0] DRP_IDX_REF_A_BW_SCALE_HIGH = 12'h0442;
    localparam logic [11:0] DRP_IDX_REF_A_LOOP_FILTER_SELECT = 12'h0443;
    localparam logic [11:0] DRP_IDX_REF_A_INT_DIV_LOW = 12'h0444;
    localparam logic [11:0] DRP_IDX_REF_A_INT_DIV_MID = 12'h0445;
    localparam logic [11:0] DRP_IDX_REF_A_INT_DIV_TOP = 12'h0446;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_NUM_LOW = 12'h0447;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_NUM_MID = 12'h0448;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_NUM_TOP = 12'h0449;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_MOD_LOW = 12'h044A;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_MOD_MID = 12'h044B;
    localparam logic [11:0] DRP_IDX_REF_A_FRAC_MOD_TOP = 12'h044C;
    localparam logic [11:0] DRP_IDX_REF_B_PRIORITY_ENABLE = 12'h044D;

    // ********************************************************************
    // Slot numbers inside the bank (index minus base).
    // ********************************************************************
    localparam int DRP_S_A_PRIO = 0;
    localparam int DRP_S_BW_LO = 1;
    localparam int DRP_S_BW_HI = 2;
    localparam int DRP_S_FILT = 3;
    localparam int DRP_S_INT_LO = 4;
    localparam int DRP_S_INT_MID = 5;
    localparam int DRP_S_INT_TOP = 6;
    localparam int DRP_S_NUM_LO = 7;
    localparam int DRP_S_NUM_MID = 8;
    localparam int DRP_S_NUM_TOP = 9;
    localparam int DRP_S_MOD_LO = 10;
    localparam int DRP_S_MOD_MID = 11;
    localparam int DRP_S_MOD_TOP = 12;
    localparam int DRP_S_B_PRIO = 13;

    // ********************************************************************
    // Field positions.
    // ********************************************************************
    localparam int DRP_ENABLE_BIT = 0;
    localparam int DRP_PRIO_LSB = 1;
    localparam int DRP_PRIO_MSB = 2;
    localparam int DRP_FILTER_BIT = 1;

    // ********************************************************************
    // Values after reset and writable bits, per slot.
    // ********************************************************************
    localparam logic [7:0] DRP_RESET [DRP_NUM_REGS] = '{
        8'h01, 8'hF4, 8'h01, 8'h00, 8'hCB, 8'h07, 8'h00,
        8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01};
    localparam logic [7:0] DRP_WMASK [DRP_NUM_REGS] = '{
        8'h07, 8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF, 8'h01,
        8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'h07};

    localparam logic [15:0] DRP_BW_SCALE_RESET = 16'h01F4;
    localparam logic [16:0] DRP_INT_DIV_RESET = 17'h0_07CB;
    localparam logic [22:0] DRP_FRAC_NUM_RESET = 23'h00_0004;
    localparam logic [22:0] DRP_FRAC_MOD_RESET = 23'h00_0005;

    typedef enum logic {DRP_SEL_REF_A, DRP_SEL_REF_B} drp_ref_sel_t;

endpackage : drp_pkg

// file: test/drp_profile_regs_tb.sv
// Self-checking testbench for the reference profile register bank.
`timescale 1ns/100ps
`default_nettype none

module drp_profile_regs_tb;
    import drp_pkg::*;

    // ****************************************************************
    // Signals and expectations
    // ****************************************************************
    localparam int TIMEOUT_CYCLES = 20000;
    localparam logic [15:0] BASE_ADDR = 16'h1100;
    logic pclk, presetn, pce, psel, penable, pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0] pstrb;
    logic pready, pslverr, rd_err;
    drp_ref_sel_t ref_sel;
    logic [15:0] ref_b_bw_scale, sel_bw_scale;
    logic ref_b_filter_high_pm, sel_filter_high_pm;
    logic [16:0] ref_b_fb_integer_part, sel_fb_integer_part;
    logic [17:0] sel_effective_integer_divide;
    logic [22:0] ref_b_fb_frac_numerator, ref_b_fb_frac_modulus;
    logic [22:0] sel_fb_frac_numerator, sel_fb_frac_modulus;
    logic [1:0] ref_input_a_priority, ref_input_b_priority;
    logic ref_input_a_enable, ref_input_b_enable;
    int n_mismatch, check_count, cycle_count;
    logic [7:0] exp_reset [14] = '{8'h01, 8'hF4, 8'h01, 8'h00, 8'hCB,
        8'h07, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h01};
    logic [7:0] exp_mask [14] = '{8'h07, 8'hFF, 8'hFF, 8'h02, 8'hFF,
        8'hFF, 8'h01, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'h07};

    drp_profile_regs drp_profile_regs_inst (
        .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_sel(ref_sel),
        .ref_b_bw_scale(ref_b_bw_scale),
        .ref_b_filter_high_pm(ref_b_filter_high_pm),
        .ref_b_fb_integer_part(ref_b_fb_integer_part),
        .ref_b_fb_frac_numerator(ref_b_fb_frac_numerator),
        .ref_b_fb_frac_modulus(ref_b_fb_frac_modulus),
        .ref_input_a_priority(ref_input_a_priority),
        .ref_input_a_enable(ref_input_a_enable),
        .ref_input_b_priority(ref_input_b_priority),
        .ref_input_b_enable(ref_input_b_enable),
        .sel_bw_scale(sel_bw_scale),
        .sel_filter_high_pm(sel_filter_high_pm),
        .sel_fb_integer_part(sel_fb_integer_part),
        .sel_effective_integer_divide(sel_effective_integer_divide),
        .sel_fb_frac_numerator(sel_fb_frac_numerator),
        .sel_fb_frac_modulus(sel_fb_frac_modulus));

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [15:0] addr,
                       input logic [7:0] wd, input logic [3:0] strb);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h00_0000, wd};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input int slot, input logic [7:0] d);
        apb(1'b1, BASE_ADDR + 16'(slot * 4), d, 4'h1);
        chk("write error", 32'h0000_0000, {31'h0, rd_err});
    endtask : wr

    task automatic rdc(input int slot, input logic [7:0] exp);
        apb(1'b0, BASE_ADDR + 16'(slot * 4), 8'h00, 4'h0);
        chk("read data", {24'h00_0000, exp}, rd_data);
        chk("read error", 32'h0000_0000, {31'h0, rd_err});
    endtask : rdc

    // Outputs are registered once more, at the edge after the access edge.
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task automatic chk_sw(input logic [1:0] ap, input logic ae,
                          input logic [1:0] bp, input logic be);
        chk("a priority", 32'(ap), 32'(ref_input_a_priority));
        chk("a enable", 32'(ae), 32'(ref_input_a_enable));
        chk("b priority", 32'(bp), 32'(ref_input_b_priority));
        chk("b enable", 32'(be), 32'(ref_input_b_enable));
    endtask : chk_sw

    task automatic chk_prof(input logic [15:0] bw, input logic filt,
        input logic [16:0] n, input logic [22:0] num, input logic [22:0] md);
        chk("bandwidth", 32'(bw), 32'(sel_bw_scale));
        chk("filter", 32'(filt), 32'(sel_filter_high_pm));
        chk("integer part", 32'(n), 32'(sel_fb_integer_part));
        chk("effective", 32'(n) + 32'h1,
            32'(sel_effective_integer_divide));
        chk("numerator", 32'(num), 32'(sel_fb_frac_numerator));
        chk("modulus", 32'(md), 32'(sel_fb_frac_modulus));
    endtask : chk_prof

    task automatic end_of_test();
        if (n_mismatch == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        chk_sw(2'd0, 1'b1, 2'd0, 1'b1);
        chk_prof(16'h01F4, 1'b0, 17'h0_07CB, 23'h4, 23'h5);
        for (int s = 0; s < 14; s++)
            rdc(s, exp_reset[s]);
    endtask : t_reset

    task automatic t_masks();
        for (int s = 0; s < 14; s++)
            wr(s, 8'hFF);
        for (int s = 0; s < 14; s++)
            rdc(s, exp_mask[s]);
        settle();
        chk_prof(16'hFFFF, 1'b1, 17'h1_FFFF, 23'h7F_FFFF, 23'h7F_FFFF);
        for (int s = 0; s < 14; s++)
            wr(s, 8'h00);
        for (int s = 0; s < 14; s++)
            rdc(s, 8'h00);
        settle();
        chk_prof(16'h0000, 1'b0, 17'h0_0000, 23'h0, 23'h0);
        chk_sw(2'd0, 1'b0, 2'd0, 1'b0);
    endtask : t_masks

    task automatic t_codes();
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 2; e++) begin
                wr(DRP_S_A_PRIO, 8'(p * 2 + e));
                wr(DRP_S_B_PRIO, 8'((3 - p) * 2 + 1 - e));
                settle();
                chk_sw(2'(p), 1'(e), 2'(3 - p), 1'(1 - e));
            end
        end
    endtask : t_codes

    task automatic t_bytes();
        logic [7:0] d [13] = '{8'h07, 8'h34, 8'h12, 8'h02, 8'h44, 8'h33,
            8'h01, 8'h56, 8'h34, 8'h92, 8'h9A, 8'h78, 8'hD6};
        // A bandwidth of 466.0 Hz stays above the 50 Hz crystal floor and
        // suits any phase detector faster than 9.32 kHz.
        for (int s = 0; s < 13; s++)
            wr(s, d[s]);
        settle();
        chk_prof(16'h1234, 1'b1, 17'h1_3344, 23'h12_3456,
            23'h56_789A);
    endtask : t_bytes

    task automatic t_refused();
        logic [15:0] bad [3] = '{16'h1138, 16'h10FC, 16'h1101};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, bad[i], 8'hFF, 4'h1);
            chk("refused error", 32'h0000_0001, {31'h0, rd_err});
            apb(1'b0, bad[i], 8'h00, 4'h0);
            chk("refused data", 32'h0000_0000, rd_data);
            chk("refused read error", 32'h0000_0001, {31'h0, rd_err});
        end
        apb(1'b1, BASE_ADDR + 16'h0004, 8'hAA, 4'h0);
        rdc(DRP_S_A_PRIO, 8'h07);
        rdc(DRP_S_BW_LO, 8'h34);
    endtask : t_refused

    task automatic t_ref_b();
        ref_b_bw_scale <= 16'hBEEF;
        ref_b_filter_high_pm <= 1'b0;
        ref_b_fb_integer_part <= 17'h1_0F0F;
        ref_b_fb_frac_numerator <= 23'h2A_5A5A;
        ref_b_fb_frac_modulus <= 23'h35_A5A5;
        ref_sel <= DRP_SEL_REF_B;
        settle();
        chk_prof(16'hBEEF, 1'b0, 17'h1_0F0F, 23'h2A_5A5A, 23'h35_A5A5);
        @(posedge pclk);
        ref_sel <= DRP_SEL_REF_A;
        settle();
        chk_prof(16'h1234, 1'b1, 17'h1_3344, 23'h12_3456, 23'h56_789A);
    endtask : t_ref_b

    // With the clock enable low the selected profile must not follow a
    // change of reference; it catches up once the enable returns.
    task automatic t_freeze();
        @(posedge pclk);
        pce <= 1'b0;
        ref_sel <= DRP_SEL_REF_B;
        settle();
        chk_prof(16'h1234, 1'b1, 17'h1_3344, 23'h12_3456,
            23'h56_789A);
        @(posedge pclk);
        pce <= 1'b1;
        settle();
        chk_prof(16'hBEEF, 1'b0, 17'h1_0F0F, 23'h2A_5A5A,
            23'h35_A5A5);
        @(posedge pclk);
        ref_sel <= DRP_SEL_REF_A;
    endtask : t_freeze

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // A hung handshake ends the run through the normal closing report.
    always @(posedge pclk) begin
        cycle_count++;
        if (cycle_count == TIMEOUT_CYCLES) begin
            n_mismatch++;
            end_of_test();
        end
    end

    initial begin
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        ref_sel = DRP_SEL_REF_A;
        ref_b_bw_scale = 16'h0000;
        ref_b_filter_high_pm = 1'b0;
        ref_b_fb_integer_part = 17'h0_0000;
        ref_b_fb_frac_numerator = 23'h00_0000;
        ref_b_fb_frac_modulus = 23'h00_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        t_reset();
        t_masks();
        t_codes();
        t_bytes();
        t_refused();
        t_ref_b();
        t_freeze();
        end_of_test();
    end

endmodule : drp_profile_regs_tb

`default_nettype wire
